// ### rtl/spm_counter.sv
`timescale 1ns/100ps
`default_nettype none

module spm_counter #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         reset_n,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         run,
  output logic              done
);

  logic [W-1:0] cnt_q;

  // Counts down once per enabled cycle, stopping at zero; done is set on the step from one to zero and held until load or reset
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cnt_q <= '0;
      done  <= 1'b0;
    end else if (load) begin
      cnt_q <= load_val;
      done  <= 1'b0;
    end else if (run && cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
      done  <= (cnt_q == {{(W-1){1'b0}}, 1'b1});
    end
  end

endmodule : spm_counter

`default_nettype wire

// ### rtl/spm_pkg.sv
package spm_pkg;

  // Register addresses on the internal serial register port
  localparam logic [15:0] ADDR_REVISION     = 16'h300D;
  localparam logic [15:0] ADDR_ID_OVERRIDE  = 16'h300C;
  localparam logic [15:0] ADDR_STREAM_CTRL  = 16'h3012;
  localparam logic [15:0] ADDR_SOFT_RESET   = 16'h3013;
  localparam logic [15:0] ADDR_EARLY_ACT    = 16'h3014;
  localparam logic [15:0] ADDR_PAD_CTRL     = 16'h3488;
  localparam logic [15:0] ADDR_PAD_OE       = 16'h3489;
  localparam logic [15:0] ADDR_PAD_VAL      = 16'h348A;
  localparam logic [15:0] ADDR_PAD_FUNC     = 16'h348B;

  // Field positions
  localparam int BIT_STREAM_EN      = 0;
  localparam int BIT_SOFT_RESET     = 0;
  localparam int BIT_EARLY_PLL      = 1;
  localparam int BIT_ANALOG_UP      = 2;
  localparam int BIT_VID_DRIVE_EN   = 4;
  localparam int BIT_VID_DRIVE_VAL  = 5;
  localparam int BIT_PAD0           = 0;
  localparam int BIT_PAD1           = 1;
  localparam int FUNC0_HI           = 7;
  localparam int FUNC0_LO           = 5;
  localparam int FUNC1_HI           = 4;
  localparam int FUNC1_LO           = 3;

  // Reset values
  localparam logic [7:0] RST_PAD_CTRL  = 8'h00;
  localparam logic [7:0] RST_PAD_OE    = 8'h00;
  localparam logic [7:0] RST_PAD_VAL   = 8'h00;
  localparam logic [7:0] RST_PAD_FUNC  = 8'h04;
  localparam logic [7:0] RST_GENERIC   = 8'h00;
  localparam logic [6:0] BUS_ID_DEFAULT = 7'h36;  // 8-bit form 6C
  localparam logic [6:0] BUS_ID_FIXED   = 7'h10;  // 8-bit form 20
  localparam logic [7:0] RST_ID_OVERRIDE = 8'h6C;

  // Pad function codes
  localparam logic [2:0] F0_ROW_TRIG  = 3'h1;
  localparam logic [2:0] F0_PLL1_LOCK = 3'h4;
  localparam logic [2:0] F0_PLL2_LOCK = 3'h5;
  localparam logic [2:0] F0_WATCHDOG  = 3'h6;
  localparam logic [1:0] F1_VSYNC     = 2'h1;
  localparam logic [1:0] F1_SEQ_PAD   = 2'h3;

  // Timing counts in reference-clock cycles, except the init count, which is in PLL ticks, and the two times given in milliseconds
  localparam int BOOT_WAIT_CYCLES     = 9500;
  localparam int REG_WAKE_CYCLES      = 32767;
  localparam int PLL_SETTLE_CYCLES    = 4096;
  localparam int INIT_WAIT_CYCLES     = 256;  // Post-lock init, in PLL ticks
  localparam int POWER_DOWN_PULSE_MS  = 1;
  localparam int SOFT_RESET_SETTLE_MS = 10;
  localparam int CLK_HZ               = 25000000;
  localparam int CNT_W                = 16;

  // One register write or read request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } spm_req_t;

  // Modes shown to the rest of the sensor
  typedef struct packed {
    logic clocks_on;
    logic pll_on;
    logic analog_on;
    logic pll_clock_sel;
    logic regulator_low;
    logic streaming;
  } spm_mode_t;

endpackage : spm_pkg

// ### rtl/spm_sequencer.sv
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Video pads follow drive value when enabled
// - Pad output enables from bits 1,0
// - Pad output levels from bits 1,0
// - Pad zero function select, bits 7:5
// - Pad one function select, bits 4:3
// - Revision code readable at fixed address
// - Latch pad one at power, hard, soft reset
// - Pad low: 6C or override; high: 20
// - Boot wait 9500 cycles after power-on reset
// - Reset pin low extends boot wait
// - Soft-reset write from any state except power down and wake, with the reset pin high
// - Boot wait counted after reset and clock
// - Power down only from standby, pin low
// - Wait 32767 cycles leaving regulator low power
// - Soft reset restores defaults, ends in standby
// - Reset pin: all reset, tri-state, bus ignored
// - Power down: clocks blocked, bus off
// - Standby after boot or stream bit clear
// - Stream set: PLL, 4096 wait, init, stream
// - Stream clear: finish frame, then standby
// - Early PLL needs analog-up bit too
// - Pads follow registers when reset released
module spm_sequencer #(
  parameter int         BOOT_CYCLES  = spm_pkg::BOOT_WAIT_CYCLES,
  parameter int         WAKE_CYCLES  = spm_pkg::REG_WAKE_CYCLES,
  parameter int         PLL_CYCLES   = spm_pkg::PLL_SETTLE_CYCLES,
  parameter int         INIT_CYCLES  = spm_pkg::INIT_WAIT_CYCLES,
  parameter logic [7:0] REVISION     = 8'hA5,  // Arbitrary value
  parameter int         VID_PADS     = 16
) (
  // Clock and power-on reset
  input  wire logic                  mclk,
  input  wire logic                  reset_n,
  // Control pins from the host
  input  wire logic                  hard_reset_pin_n,
  input  wire logic                  power_down_pin_n,
  // Register port from the serial bus slave
  input  wire spm_pkg::spm_req_t     reg_req,
  output logic [7:0]                 reg_rdata,
  output logic                       reg_rvalid,
  output logic [6:0]                 bus_id,
  output logic                       bus_enable,
  // Events from the sensor
  input  wire logic                  frame_sync_in,
  input  wire logic                  row_trigger,
  input  wire logic                  pll1_lock,
  input  wire logic                  pll2_lock,
  input  wire logic                  watchdog_pulse,
  input  wire logic                  seq_pad_signal,
  input  wire logic                  pll_clock_tick,
  // General pads
  input  wire logic                  general_pad_zero_in,
  output logic                       general_pad_zero_out,
  output logic                       general_pad_zero_oe,
  input  wire logic                  general_pad_one_in,
  output logic                       general_pad_one_out,
  output logic                       general_pad_one_oe,
  // Video pads
  output logic [VID_PADS-1:0]        video_pad_out,
  output logic [VID_PADS-1:0]        video_pad_oe,
  // Mode
  output spm_pkg::spm_mode_t         mode,
  output logic                       soft_reset_state
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic rst_pin_n_s;
  logic pwdn_pin_n_s;
  logic fsync_s;
  logic pad1_s;
  logic pad0_s;
  logic pll_tick_s;
  logic [4:0] evt_s;

  // Sensor events come from other clocks, so they take the same two stages
  spm_sync #(.W(11)) u_sync (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .async_in ({hard_reset_pin_n, power_down_pin_n, frame_sync_in,
                general_pad_one_in, general_pad_zero_in, pll_clock_tick,
                row_trigger, pll1_lock, pll2_lock, watchdog_pulse, seq_pad_signal}),
    .sync_out ({rst_pin_n_s, pwdn_pin_n_s, fsync_s, pad1_s, pad0_s, pll_tick_s, evt_s})
  );

  ////////////////////////////////////////////////////////////////////////////////
  // State machine
  typedef enum logic [8:0] {
    ST_BOOT     = 9'h001,
    ST_SOFT_RST = 9'h002,
    ST_STANDBY  = 9'h004,
    ST_PWDN     = 9'h008,
    ST_WAKE     = 9'h010,
    ST_PLL_UP   = 9'h020,
    ST_INIT     = 9'h040,
    ST_STREAM   = 9'h080,
    ST_STOPPING = 9'h100
  } spm_state_t;

  spm_state_t state_q;
  spm_state_t state_d;

  logic [7:0] pad_ctrl_q;
  logic [7:0] pad_oe_q;
  logic [7:0] pad_val_q;
  logic [7:0] pad_func_q;
  logic [7:0] id_ovr_q;
  logic [7:0] stream_q;
  logic [7:0] early_q;
  logic       id_strap_q;
  logic       fsync_d1_q;

  // Register file is live only outside reset pin, power down and wake
  wire        regs_live  = rst_pin_n_s && state_q != ST_PWDN && state_q != ST_WAKE;
  wire        wr_ok      = regs_live && reg_req.wr;
  wire        soft_rst   = wr_ok && reg_req.addr == spm_pkg::ADDR_SOFT_RESET
                           && reg_req.wdata[spm_pkg::BIT_SOFT_RESET];
  wire        stream_en  = stream_q[spm_pkg::BIT_STREAM_EN];
  wire        early_pll  = early_q[spm_pkg::BIT_EARLY_PLL] && early_q[spm_pkg::BIT_ANALOG_UP];
  wire        analog_up  = early_q[spm_pkg::BIT_ANALOG_UP];
  wire        frame_end  = fsync_s && !fsync_d1_q;
  wire        regs_clear = !rst_pin_n_s || soft_rst || state_q == ST_PWDN;

  ////////////////////////////////////////////////////////////////////////////////
  // Timers
  logic [spm_pkg::CNT_W-1:0] tmr_load_val;
  logic                      tmr_load;
  logic                      tmr_done;
  logic                      tmr_run;

  function automatic logic [spm_pkg::CNT_W-1:0] to_cnt(input int n);
    to_cnt = n[spm_pkg::CNT_W-1:0];
  endfunction : to_cnt

  assign tmr_load     = (state_q != state_d) || !rst_pin_n_s;
  assign tmr_load_val = (state_d == ST_BOOT)   ? to_cnt(BOOT_CYCLES) :
                        (state_d == ST_WAKE)   ? to_cnt(WAKE_CYCLES) :
                        (state_d == ST_PLL_UP) ? to_cnt(PLL_CYCLES)  :
                        (state_d == ST_INIT)   ? to_cnt(INIT_CYCLES) : to_cnt(1);
  assign tmr_run      = (state_q == ST_INIT) ? pll_tick_s : 1'b1;

  spm_counter #(.W(spm_pkg::CNT_W)) u_timer (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .load     (tmr_load),
    .load_val (tmr_load_val),
    .run      (tmr_run),
    .done     (tmr_done)
  );

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_BOOT:     if (tmr_done) state_d = ST_SOFT_RST;
      ST_SOFT_RST: state_d = ST_STANDBY;
      ST_STANDBY: begin
        if (!pwdn_pin_n_s) state_d = ST_PWDN;
        else if (stream_en) state_d = ST_PLL_UP;
      end
      ST_PWDN:     if (pwdn_pin_n_s) state_d = ST_WAKE;
      ST_WAKE:     if (tmr_done) state_d = ST_STANDBY;
      ST_PLL_UP: begin
        if (!stream_en) state_d = ST_STANDBY;
        else if (tmr_done) state_d = ST_INIT;
      end
      ST_INIT: begin
        if (!stream_en) state_d = ST_STANDBY;
        else if (tmr_done) state_d = ST_STREAM;
      end
      ST_STREAM:   if (!stream_en) state_d = ST_STOPPING;
      ST_STOPPING: begin
        if (stream_en) state_d = ST_STREAM;
        else if (frame_end) state_d = ST_STANDBY;
      end
      default:     state_d = ST_BOOT;
    endcase
    if (soft_rst) state_d = ST_SOFT_RST;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n || !rst_pin_n_s) begin
      state_q <= ST_BOOT;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      fsync_d1_q <= 1'b0;
    end else begin
      fsync_d1_q <= fsync_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers
  function automatic logic [7:0] wr_val(input logic [15:0] a, input logic [7:0] cur);
    wr_val = (wr_ok && reg_req.addr == a) ? reg_req.wdata : cur;
  endfunction : wr_val

  always_ff @(posedge mclk) begin
    if (!reset_n || regs_clear) begin
      pad_ctrl_q <= spm_pkg::RST_PAD_CTRL;
      pad_oe_q   <= spm_pkg::RST_PAD_OE;
      pad_val_q  <= spm_pkg::RST_PAD_VAL;
      pad_func_q <= spm_pkg::RST_PAD_FUNC;
      id_ovr_q   <= spm_pkg::RST_ID_OVERRIDE;
      stream_q   <= spm_pkg::RST_GENERIC;
      early_q    <= spm_pkg::RST_GENERIC;
    end else begin
      pad_ctrl_q <= wr_val(spm_pkg::ADDR_PAD_CTRL, pad_ctrl_q);
      pad_oe_q   <= wr_val(spm_pkg::ADDR_PAD_OE, pad_oe_q);
      pad_val_q  <= wr_val(spm_pkg::ADDR_PAD_VAL, pad_val_q);
      pad_func_q <= wr_val(spm_pkg::ADDR_PAD_FUNC, pad_func_q);
      id_ovr_q   <= wr_val(spm_pkg::ADDR_ID_OVERRIDE, id_ovr_q);
      stream_q   <= wr_val(spm_pkg::ADDR_STREAM_CTRL, stream_q);
      early_q    <= wr_val(spm_pkg::ADDR_EARLY_ACT, early_q);
    end
  end

  // Address strap sampled in reset pin, boot and soft reset states, kept afterwards
  wire strap_window = !rst_pin_n_s || state_q == ST_BOOT || state_q == ST_SOFT_RST;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      id_strap_q <= 1'b0;
    end else if (strap_window) begin
      id_strap_q <= pad1_s;
    end
  end

  wire [7:0] rd_mux =
    (reg_req.addr == spm_pkg::ADDR_REVISION)    ? REVISION   :
    (reg_req.addr == spm_pkg::ADDR_ID_OVERRIDE) ? id_ovr_q   :
    (reg_req.addr == spm_pkg::ADDR_STREAM_CTRL) ? stream_q   :
    (reg_req.addr == spm_pkg::ADDR_EARLY_ACT)   ? early_q    :
    (reg_req.addr == spm_pkg::ADDR_PAD_CTRL)    ? pad_ctrl_q :
    (reg_req.addr == spm_pkg::ADDR_PAD_OE)      ? pad_oe_q   :
    (reg_req.addr == spm_pkg::ADDR_PAD_VAL)     ? pad_val_q  :
    (reg_req.addr == spm_pkg::ADDR_PAD_FUNC)    ? pad_func_q : 8'h00;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= regs_live && reg_req.rd;
      reg_rdata  <= (regs_live && reg_req.rd) ? rd_mux : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pads
  wire [2:0] f0 = pad_func_q[spm_pkg::FUNC0_HI:spm_pkg::FUNC0_LO];
  wire [1:0] f1 = pad_func_q[spm_pkg::FUNC1_HI:spm_pkg::FUNC1_LO];

  // Unused codes fall back to the output-value register
  wire pad0_src = (f0 == spm_pkg::F0_ROW_TRIG)  ? evt_s[4] :
                  (f0 == spm_pkg::F0_PLL1_LOCK) ? evt_s[3] :
                  (f0 == spm_pkg::F0_PLL2_LOCK) ? evt_s[2] :
                  (f0 == spm_pkg::F0_WATCHDOG)  ? evt_s[1] :
                  pad_val_q[spm_pkg::BIT_PAD0];
  wire pad1_src = (f1 == spm_pkg::F1_VSYNC)   ? fsync_s        :
                  (f1 == spm_pkg::F1_SEQ_PAD) ? evt_s[0] :
                  pad_val_q[spm_pkg::BIT_PAD1];

  wire pads_on = rst_pin_n_s;
  wire vid_en  = pads_on && pad_ctrl_q[spm_pkg::BIT_VID_DRIVE_EN];

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      general_pad_zero_out <= 1'b0;
      general_pad_zero_oe  <= 1'b0;
      general_pad_one_out  <= 1'b0;
      general_pad_one_oe   <= 1'b0;
      video_pad_out        <= '0;
      video_pad_oe         <= '0;
    end else begin
      general_pad_zero_out <= pad0_src;
      general_pad_zero_oe  <= pads_on && pad_oe_q[spm_pkg::BIT_PAD0];
      general_pad_one_out  <= pad1_src;
      general_pad_one_oe   <= pads_on && pad_oe_q[spm_pkg::BIT_PAD1];
      video_pad_out        <= {VID_PADS{pad_ctrl_q[spm_pkg::BIT_VID_DRIVE_VAL]}};
      video_pad_oe         <= {VID_PADS{vid_en}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus identity and mode outputs
  wire in_run = state_q == ST_PLL_UP || state_q == ST_INIT
                || state_q == ST_STREAM || state_q == ST_STOPPING;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      bus_id           <= spm_pkg::BUS_ID_DEFAULT;
      bus_enable       <= 1'b0;
      mode             <= '0;
      soft_reset_state <= 1'b0;
    end else begin
      bus_id           <= id_strap_q ? spm_pkg::BUS_ID_FIXED : id_ovr_q[7:1];
      bus_enable       <= regs_live;
      soft_reset_state <= state_q == ST_SOFT_RST;
      mode.clocks_on     <= rst_pin_n_s && state_q != ST_PWDN && state_q != ST_WAKE;
      mode.analog_on     <= in_run || (state_q == ST_STANDBY && analog_up);
      mode.pll_on        <= in_run || (state_q == ST_STANDBY && early_pll);
      mode.pll_clock_sel <= state_q == ST_INIT || state_q == ST_STREAM
                            || state_q == ST_STOPPING;
      mode.regulator_low <= state_q == ST_PWDN;
      mode.streaming     <= state_q == ST_STREAM || state_q == ST_STOPPING;
    end
  end

endmodule : spm_sequencer

`default_nettype wire

// ### rtl/spm_sync.sv
`timescale 1ns/100ps
`default_nettype none

module spm_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         reset_n,
  // Data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // First stage is read only by the second stage
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : spm_sync

`default_nettype wire

// ### tb/spm_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module spm_host_model (
  // Clock
  input  wire logic        mclk,
  // Register port
  output spm_pkg::spm_req_t reg_req,
  input  wire logic [7:0]  reg_rdata,
  input  wire logic        reg_rvalid,
  // Control pins
  output logic             hard_reset_pin_n,
  output logic             power_down_pin_n
);
  // Pins idle high with the clock already running
  initial begin
    reg_req = '0;
    hard_reset_pin_n = 1'b1;
    power_down_pin_n = 1'b1;
  end

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    #1;
    reg_req = '0;
  endtask : wr

  // No answer leaves unknown data so a refused read never matches
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk);
    #1;
    reg_req = '0;
    d = reg_rvalid ? reg_rdata : 8'hXX;
  endtask : rd

  // Holding the pin low stretches the boot wait
  task automatic hard(input logic lvl);
    @(posedge mclk);
    #1;
    hard_reset_pin_n = lvl;
  endtask : hard

  task automatic pwdn(input logic lvl);
    @(posedge mclk);
    #1;
    power_down_pin_n = lvl;
  endtask : pwdn
endmodule : spm_host_model

`default_nettype wire

// ### tb/spm_seq_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module spm_seq_monitor #(
  parameter logic [7:0] REVISION = 8'hA5,
  parameter int         VID_PADS = 16
) (
  // Clock and reset
  input wire logic                mclk,
  input wire logic                reset_n,
  // Register port
  input wire spm_pkg::spm_req_t   reg_req,
  input wire logic [7:0]          reg_rdata,
  input wire logic                reg_rvalid,
  input wire logic                bus_enable,
  // Pads and mode
  input wire logic                general_pad_zero_oe,
  input wire logic                general_pad_one_oe,
  input wire logic [VID_PADS-1:0] video_pad_oe,
  input wire spm_pkg::spm_mode_t  mode,
  input wire logic                soft_reset_state
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_read_answer: assert property (reg_req.rd |=> reg_rvalid == bus_enable)
    else $error("Read not answered");
  a_rev_value: assert property (reg_req.rd && reg_req.addr == spm_pkg::ADDR_REVISION
    |=> reg_rdata == (bus_enable ? REVISION : 8'h00)) else $error("Revision value wrong");
  a_read_refused: assert property (!bus_enable |-> !reg_rvalid)
    else $error("Read answered while bus off");
  a_pwdn_bus_off: assert property (mode.regulator_low |-> !bus_enable)
    else $error("Bus live in power down");
  a_pwdn_no_clock: assert property (mode.regulator_low |-> !mode.clocks_on)
    else $error("Clocks on in power down");
  a_wake_hold: assert property ($fell(mode.regulator_low) |-> !mode.clocks_on [*8])
    else $error("Clocks on too early after wake");
  a_sel_after_pll: assert property ($rose(mode.pll_clock_sel) |-> mode.pll_on && $past(mode.pll_on, 8))
    else $error("Clock switched before PLL settled");
  a_stream_on_pll: assert property (mode.streaming |-> mode.pll_clock_sel && mode.pll_on)
    else $error("Streaming without PLL clock");
  a_pll_analog: assert property (mode.pll_on |-> mode.analog_on)
    else $error("PLL on without analog");
  a_soft_pulse: assert property (soft_reset_state |=> !soft_reset_state)
    else $error("Soft reset state held");
  a_soft_pads_off: assert property (soft_reset_state |-> ##2 (video_pad_oe == '0
    && !general_pad_zero_oe && !general_pad_one_oe)) else $error("Pads not back to default");

  c_stream: cover property ($rose(mode.streaming));
  c_pwdn: cover property ($rose(mode.regulator_low));
  c_soft: cover property (soft_reset_state);
endmodule : spm_seq_monitor

bind spm_sequencer spm_seq_monitor #(.REVISION(REVISION), .VID_PADS(VID_PADS)) i_mon (
  .mclk(mclk), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .bus_enable(bus_enable), .general_pad_zero_oe(general_pad_zero_oe), .general_pad_one_oe(general_pad_one_oe),
  .video_pad_oe(video_pad_oe), .mode(mode), .soft_reset_state(soft_reset_state));

`default_nettype wire

// ### tb/spm_sequencer_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module spm_sequencer_tb_top;
  localparam int         BOOT = 20;
  localparam int         WAKE = 30;
  localparam int         PLLC = 10;
  localparam int         INIT = 8;
  localparam logic [7:0] REV  = 8'h5A;  // Arbitrary value

  logic               mclk = 1'b0;
  logic               reset_n = 1'b0;
  spm_pkg::spm_req_t  reg_req;
  logic [7:0]         reg_rdata, d;
  logic               reg_rvalid, bus_enable, hrst_n, pwdn_n, fs, soft_reset_state;
  logic               tick = 1'b0;
  logic [6:0]         bus_id;
  logic [4:0]         src;
  logic [1:0]         pad_in, pad_out, pad_oe;
  logic [15:0]        vid_out, vid_oe;
  spm_pkg::spm_mode_t mode;
  int                 errors = 0, total_checks = 0, cycles = 0, n, i;
  logic [15:0]        ra[5] = '{spm_pkg::ADDR_PAD_OE, spm_pkg::ADDR_PAD_VAL, spm_pkg::ADDR_PAD_FUNC,
                                spm_pkg::ADDR_REVISION, 16'h1234};
  logic [7:0]         rv[5] = '{8'h00, 8'h00, 8'h04, REV, 8'h00};
  logic [7:0]         fsel[8] = '{8'h20, 8'h80, 8'hA0, 8'hC0, 8'h40, 8'h18, 8'h08, 8'h10};
  logic [1:0]         fexp[8] = '{2'b01, 2'b01, 2'b01, 2'b01, 2'b00, 2'b10, 2'b10, 2'b00};
  // One source at a time for used codes, all sources high for unused pad zero code 2, all but frame sync for unused pad one code 2, so a wrong route shows
  logic [5:0]         fsrc[8] = '{6'h10, 6'h08, 6'h04, 6'h02, 6'h3F, 6'h01, 6'h20, 6'h1F};

  always #20 mclk = ~mclk;

  // Half-rate tick: init must count ticks, not cycles
  always @(posedge mclk) tick <= #1 ~tick;

  spm_sequencer #(.BOOT_CYCLES(BOOT), .WAKE_CYCLES(WAKE), .PLL_CYCLES(PLLC), .INIT_CYCLES(INIT),
    .REVISION(REV), .VID_PADS(16)) i_dut (
    .mclk(mclk), .reset_n(reset_n), .hard_reset_pin_n(hrst_n), .power_down_pin_n(pwdn_n),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .bus_id(bus_id),
    .bus_enable(bus_enable), .frame_sync_in(fs), .row_trigger(src[4]), .pll1_lock(src[3]),
    .pll2_lock(src[2]), .watchdog_pulse(src[1]), .seq_pad_signal(src[0]), .pll_clock_tick(tick),
    .general_pad_zero_in(pad_in[0]), .general_pad_zero_out(pad_out[0]), .general_pad_zero_oe(pad_oe[0]),
    .general_pad_one_in(pad_in[1]), .general_pad_one_out(pad_out[1]), .general_pad_one_oe(pad_oe[1]),
    .video_pad_out(vid_out), .video_pad_oe(vid_oe), .mode(mode), .soft_reset_state(soft_reset_state));

  spm_host_model i_host (
    .mclk(mclk), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .hard_reset_pin_n(hrst_n), .power_down_pin_n(pwdn_n));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic step(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : step

  task automatic wait_soft();
    n = 0;
    while (soft_reset_state !== 1'b1 && n < 200) begin
      step(1);
      n++;
    end
  endtask : wait_soft

  task automatic complete_run();
    $display("Checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  // Whole run is a few hundred cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    src = 5'h00; fs = 1'b0; pad_in = 2'b00;
    step(8);
    reset_n = 1'b1;
    wait_soft();
    chk("boot_wait", 16'(n >= BOOT && n <= BOOT + 8), 16'h0001);
    step(3);
    for (i = 0; i < 5; i++) begin
      i_host.rd(ra[i], d);
      chk("reg_reset", {8'h00, d}, {8'h00, rv[i]});
    end
    i_host.wr(spm_pkg::ADDR_PAD_OE, 8'h03);
    i_host.wr(spm_pkg::ADDR_PAD_VAL, 8'h02);
    step(3);
    chk("pad_oe", {14'h0000, pad_oe}, 16'h0003);
    chk("pad_out", {14'h0000, pad_out}, 16'h0002);
    i_host.wr(spm_pkg::ADDR_PAD_VAL, 8'h00);
    for (i = 0; i < 8; i++) begin
      {fs, src} = fsrc[i];
      i_host.wr(spm_pkg::ADDR_PAD_FUNC, fsel[i]);
      step(3);
      chk("pad_route", {14'h0000, pad_out}, {14'h0000, fexp[i]});
    end
    i_host.wr(spm_pkg::ADDR_PAD_CTRL, 8'h30);
    step(3);
    chk("vid_oe", vid_oe, 16'hFFFF);
    chk("vid_out", vid_out, 16'hFFFF);
    i_host.wr(spm_pkg::ADDR_PAD_CTRL, 8'h10);
    step(3);
    chk("vid_out", vid_out, 16'h0000);
    chk("bus_id", {9'h000, bus_id}, 16'h0036);
    i_host.wr(spm_pkg::ADDR_ID_OVERRIDE, 8'h40);
    step(3);
    chk("bus_id", {9'h000, bus_id}, 16'h0020);
    // Soft reset with pad one strapped high
    pad_in = 2'b10;
    i_host.wr(spm_pkg::ADDR_SOFT_RESET, 8'h01);
    wait_soft();
    chk("soft_seen", 16'(n < 200), 16'h0001);
    step(3);
    chk("bus_id", {9'h000, bus_id}, 16'h0010);
    i_host.rd(spm_pkg::ADDR_PAD_OE, d);
    chk("soft_default", {8'h00, d}, 16'h0000);
    // Pin reset with pad one low; write in reset must be lost
    pad_in = 2'b01;
    i_host.wr(spm_pkg::ADDR_PAD_OE, 8'h03);
    i_host.hard(1'b0);
    step(4);
    chk("rst_bus", {15'h0000, bus_enable}, 16'h0000);
    i_host.wr(spm_pkg::ADDR_PAD_OE, 8'h03);
    step(2);
    chk("rst_oe", {14'h0000, pad_oe}, 16'h0000);
    i_host.hard(1'b1);
    wait_soft();
    chk("boot_wait", 16'(n >= BOOT && n <= BOOT + 8), 16'h0001);
    step(3);
    chk("bus_id", {9'h000, bus_id}, 16'h0036);
    i_host.rd(spm_pkg::ADDR_PAD_OE, d);
    chk("rst_lost", {8'h00, d}, 16'h0000);
    // Activation
    i_host.wr(spm_pkg::ADDR_STREAM_CTRL, 8'h01);
    n = 0;
    while (mode.pll_clock_sel !== 1'b1 && n < 100) begin
      step(1);
      n++;
    end
    chk("pll_wait", 16'(n >= PLLC - 2 && n <= PLLC + 4), 16'h0001);
    n = 0;
    while (mode.streaming !== 1'b1 && n < 100) begin
      step(1);
      n++;
    end
    chk("init_wait", 16'(n >= 2 * INIT - 2 && n <= 2 * INIT + 6), 16'h0001);
    i_host.pwdn(1'b0);
    step(6);
    chk("pwdn_stream", {15'h0000, mode.regulator_low}, 16'h0000);
    i_host.pwdn(1'b1);
    // Deactivation waits for frame end
    i_host.wr(spm_pkg::ADDR_STREAM_CTRL, 8'h00);
    step(6);
    chk("stop_hold", {15'h0000, mode.streaming}, 16'h0001);
    fs = 1'b1;
    step(6);
    fs = 1'b0;
    chk("stop_mode", {10'h000, mode}, 16'h0020);
    // Power down and wake
    i_host.pwdn(1'b0);
    step(6);
    chk("pwdn_mode", {10'h000, mode}, 16'h0002);
    chk("pwdn_bus", {15'h0000, bus_enable}, 16'h0000);
    i_host.pwdn(1'b1);
    n = 0;
    while (mode.clocks_on !== 1'b1 && n < 200) begin
      step(1);
      n++;
    end
    chk("wake_wait", 16'(n >= WAKE && n <= WAKE + 8), 16'h0001);
    step(3);
    // Early PLL needs analog bit as well
    i_host.wr(spm_pkg::ADDR_EARLY_ACT, 8'h02);
    step(3);
    chk("early_pll", {15'h0000, mode.pll_on}, 16'h0000);
    i_host.wr(spm_pkg::ADDR_EARLY_ACT, 8'h06);
    step(3);
    chk("early_pll", {14'h0000, mode.pll_on, mode.analog_on}, 16'h0003);
    complete_run();
  end
endmodule : spm_sequencer_tb_top

`default_nettype wire
